// >>> src/rte_pkg.sv
// Constants, field layouts and types for the tag readout encoder.
// Assumes one carrier-derived clock; nothing here holds state.
`default_nettype none

package rte_pkg;

  // ****************************************************************
  // Configuration word layout
  // ****************************************************************
  typedef struct packed {
    logic array_lock_bit;
    logic fixed_zero_bit;
    logic psk_carrier_divider;
    logic modulation_select_high;
    logic modulation_select_low;
    logic encoding_select_high;
    logic encoding_select_low;
    logic rate_aux_bit;
    logic rate_select_bit_c;
    logic rate_select_bit_b;
    logic rate_select_bit_a;
    logic stream_length_select;
  } rte_cfg_t;

  localparam rte_cfg_t CFG_RESET = 12'h000;

  // Encodings and modulations, as {high, low} select bits
  typedef enum logic [1:0] {ENC_DIRECT = 2'b00, ENC_DIFF = 2'b01, ENC_MANCH = 2'b10, ENC_VARIANT = 2'b11} rte_enc_t;
  typedef enum logic [1:0] {MOD_DIRECT = 2'b00, MOD_FSK = 2'b01, MOD_PSK_CHG = 2'b10, MOD_PSK_ONE = 2'b11} rte_mod_t;

  // ****************************************************************
  // Timing counts, in carrier clock cycles
  // ****************************************************************
  localparam logic [7:0] DIV_DEFAULT   = 8'h80;  // Carrier / 128
  localparam logic [7:0] GAP_CYCLES    = 8'h10;  // Field absence that counts as a gap
  localparam logic [3:0] FSK_ONE_HALF  = 4'h4;   // Carrier / 8 for a one
  localparam logic [3:0] FSK_ZERO_HALF = 4'h5;   // Carrier / 10 for a zero
  localparam logic [1:0] SYNC_HALVES   = 2'h3;   // 1.5 bits of sync
  localparam int         ARRAY_BITS    = 128;
  localparam logic [6:0] LAST_BIT_128  = 7'h7f;
  localparam logic [6:0] LAST_BIT_96   = 7'h5f;

  // Bit rate divisors selected by {c, b, a}
  localparam logic [7:0] RATE_DIV [8] = '{8'h08, 8'h10, 8'h20, 8'h28, 8'h32, 8'h40, 8'h64, 8'h80};

  // ****************************************************************
  // Register port
  // ****************************************************************
  localparam logic [1:0] REG_CONFIG = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam int         STS_GAP    = 0;  // Sticky gap flag, write one to clear
  localparam int         STS_LOCK   = 1;
  localparam int         STS_PROG   = 2;
  localparam int         STS_IDX    = 8;  // Current stream bit index, 7 bits

  // Programming pins, grouped
  typedef struct packed {
    logic active;
    logic contactless;
    logic bit_stb;
    logic bit_val;
    logic erase;
  } rte_prog_t;

endpackage

`default_nettype wire

// >>> src/rte_tag_encoder.sv
// Digital core of a passive read-only tag: array, sequencer, encoder, modulator.
// Assumes mclk is the carrier-derived clock; field, supply and programming pins are asynchronous.
//
// Operation
// - All timing derived from the carrier clock
// - Flag field gap after fixed absent cycles
// - Hold logic in reset until supply adequate
// - Encode data per two encoding select bits
// - Modulate load per two modulation select bits
// - PSK subcarrier carrier/2 or carrier/4
// - Fixed configuration bit always reads zero
// - Set lock after programming completes
// - Locked array refuses program and erase
// - Configuration never written over contactless path
// - Three bits pick return data rate
// - Programming uses carrier/128 bit rate
// - Timing settings apply only once programmed
// - Rate bit a with aux adds 1.5-bit sync
// - Step array addresses at data rate
// - Stream length 96 or 128 bits
// - Contactless programming uses 128-bit length
// - Programming addresses bits serially first to last
// - Unprogrammed: carrier/128, FSK, direct data
// - Locked tag transmits configured protocol
`default_nettype none

module rte_tag_encoder
  import rte_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        carrier_present,
  input  wire logic        supply_ok,
  input  wire rte_cfg_t    cfg_fuse,
  input  wire logic        lock_fuse,
  input  wire rte_prog_t   prog_pins,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             coil_load,
  output logic             field_gap,
  output logic             array_locked,
  output logic             tag_in_reset
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  assign pin_raw = {carrier_present, supply_ok, prog_pins};

  // Two stages per pin; only the second stage is read by logic.
  // One process for all bits, so every stage has a single driver.
  always_ff @(posedge mclk) begin
    sync1_reg <= pin_raw;
    sync2_reg <= sync1_reg;
  end

  logic      carrier_s;
  logic      supply_s;
  rte_prog_t prog_s;
  assign carrier_s = sync2_reg[6];
  assign supply_s  = sync2_reg[5];
  assign prog_s    = sync2_reg[4:0];

  // ****************************************************************
  // Internal reset and strap capture
  // ****************************************************************
  logic rst_int;
  assign rst_int = sys_rst | ~supply_s;

  logic     tag_in_reset_reg;
  logic     load_pend_reg;
  rte_cfg_t cfg_reg;
  logic     lock_reg;
  logic     set_lock;

  // Factory word is caught on the first cycle after release, never under reset
  always_ff @(posedge mclk) begin
    tag_in_reset_reg <= rst_int;
    if (rst_int) begin
      load_pend_reg <= 1'b1;
      cfg_reg       <= CFG_RESET;
    end else if (load_pend_reg) begin
      load_pend_reg <= 1'b0;
      cfg_reg       <= cfg_fuse;
      cfg_reg.fixed_zero_bit <= 1'b0;
    end
  end

  // Lock only ever sets; nothing on the contactless path reaches cfg_reg
  always_ff @(posedge mclk) begin
    if (rst_int) begin
      lock_reg <= 1'b0;
    end else if ((load_pend_reg & lock_fuse) | set_lock) begin
      lock_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // Field gap detector
  // ****************************************************************
  logic [7:0] gap_cnt_reg;
  logic       gap_hit;
  logic       field_gap_reg;
  logic       gap_flag_reg;
  logic       gap_clr;
  assign gap_hit = ~carrier_s & (gap_cnt_reg == GAP_CYCLES - 8'h01);
  assign gap_clr = reg_wr & (reg_addr == REG_STATUS) & reg_wdata[STS_GAP];

  // Pulse once per absence; the sticky copy lets set win over clear
  always_ff @(posedge mclk) begin
    if (rst_int) begin
      gap_cnt_reg   <= 8'h00;
      field_gap_reg <= 1'b0;
      gap_flag_reg  <= 1'b0;
    end else begin
      // Count saturates past the hit, so a long absence gives a single pulse
      gap_cnt_reg   <= carrier_s ? 8'h00 : ((gap_cnt_reg == GAP_CYCLES) ? gap_cnt_reg : gap_cnt_reg + 8'h01);
      field_gap_reg <= gap_hit;
      gap_flag_reg  <= (gap_hit | (gap_flag_reg & ~gap_clr));
    end
  end

  // ****************************************************************
  // Programming: serial bit writes and block erase
  // ****************************************************************
  logic [ARRAY_BITS-1:0] array_mem;
  logic [6:0]            prog_idx_reg;
  logic                  stb_d_reg;
  logic                  erase_d_reg;
  logic                  prog_ok;
  logic                  bit_wr;
  logic                  erase_go;
  assign prog_ok  = prog_s.active & ~lock_reg;
  assign bit_wr   = prog_ok & prog_s.bit_stb & ~stb_d_reg;
  assign erase_go = prog_ok & prog_s.erase & ~erase_d_reg;
  assign set_lock = bit_wr & (prog_idx_reg == LAST_BIT_128);

  always_ff @(posedge mclk) begin
    if (rst_int) begin
      stb_d_reg    <= 1'b0;
      erase_d_reg  <= 1'b0;
      prog_idx_reg <= 7'h00;
    end else begin
      stb_d_reg   <= prog_s.bit_stb;
      erase_d_reg <= prog_s.erase;
      if (erase_go | ~prog_s.active) begin
        prog_idx_reg <= 7'h00;
      end else if (bit_wr) begin
        prog_idx_reg <= prog_idx_reg + 7'h01;
      end
    end
  end

  // Array is nonvolatile: not touched by reset
  always_ff @(posedge mclk) begin
    if (erase_go) begin
      array_mem <= '0;
    end else if (bit_wr) begin
      array_mem[prog_idx_reg] <= prog_s.bit_val;
    end
  end

  // ****************************************************************
  // Effective settings
  // ****************************************************************
  logic       use_cfg;
  logic [7:0] bit_div;
  logic [6:0] half_div;
  logic [6:0] last_bit;
  logic       sync_en;
  rte_enc_t   enc_mode;
  rte_mod_t   mod_mode;

  // Defaults rule until locked and while programming
  assign use_cfg  = lock_reg & ~prog_s.active;
  assign bit_div  = use_cfg ? RATE_DIV[{cfg_reg.rate_select_bit_c, cfg_reg.rate_select_bit_b,
                                       cfg_reg.rate_select_bit_a}] : DIV_DEFAULT;
  assign half_div = bit_div[7:1];
  assign last_bit = (use_cfg & ~cfg_reg.stream_length_select) ? LAST_BIT_96 : LAST_BIT_128;
  assign sync_en  = use_cfg & cfg_reg.rate_select_bit_a & cfg_reg.rate_aux_bit;
  assign enc_mode = use_cfg ? rte_enc_t'({cfg_reg.encoding_select_high, cfg_reg.encoding_select_low})
                            : ENC_DIRECT;
  assign mod_mode = use_cfg ? rte_mod_t'({cfg_reg.modulation_select_high, cfg_reg.modulation_select_low})
                            : MOD_FSK;

  // ****************************************************************
  // Half-bit divider
  // ****************************************************************
  logic [6:0] half_cnt_reg;
  logic       half_tick;
  assign half_tick = (half_cnt_reg >= half_div - 7'h01);

  // Enable pulse every half bit period, all from the carrier clock
  always_ff @(posedge mclk) begin
    if (rst_int) begin
      half_cnt_reg <= 7'h00;
    end else begin
      half_cnt_reg <= half_tick ? 7'h00 : half_cnt_reg + 7'h01;
    end
  end

  // ****************************************************************
  // Stream sequencer and encoder
  // ****************************************************************
  // One bit changes per step along start, data, sync, data
  typedef enum logic [1:0] {ST_START = 2'b10, ST_SYNC = 2'b01, ST_DATA = 2'b11} rte_state_t;
  rte_state_t state_reg;
  logic [6:0] bit_idx_reg;
  logic       half_reg;
  logic [1:0] sync_cnt_reg;
  logic       enc_reg;
  logic       new_bit;
  logic [6:0] next_idx;
  logic       next_d;
  logic       cur_d;
  logic       enc_next;
  logic       sync_done;
  logic       sync_go;
  logic       bit_start;

  assign sync_done = (sync_cnt_reg == SYNC_HALVES - 2'h1);
  assign sync_go   = (state_reg == ST_DATA) & half_reg & (bit_idx_reg >= last_bit) & sync_en;
  // A data bit begins on this tick; sync halves are never bit edges
  assign bit_start = half_tick & new_bit & ~sync_go & ~((state_reg == ST_SYNC) & ~sync_done);
  assign new_bit   = (state_reg != ST_DATA) | half_reg;
  assign next_idx  = (state_reg != ST_DATA) ? 7'h00 : ((bit_idx_reg >= last_bit) ? 7'h00 : bit_idx_reg + 7'h01);
  assign next_d    = array_mem[next_idx];
  assign cur_d     = array_mem[bit_idx_reg];

  // Level of the half bit about to start
  always_comb begin
    enc_next = next_d;
    unique case (enc_mode)
      ENC_DIRECT:  enc_next = new_bit ? next_d : cur_d;
      ENC_DIFF:    enc_next = new_bit ? ~enc_reg : (cur_d ? enc_reg : ~enc_reg);
      ENC_MANCH:   enc_next = new_bit ? next_d : ~cur_d;
      ENC_VARIANT: enc_next = new_bit ? ~next_d : cur_d;
    endcase
  end

  // Wrapping back to bit 0 restarts with an optional sync word
  always_ff @(posedge mclk) begin
    if (rst_int) begin
      state_reg    <= ST_START;
      bit_idx_reg  <= 7'h00;
      half_reg     <= 1'b0;
      sync_cnt_reg <= 2'h0;
      enc_reg      <= 1'b0;
    end else if (half_tick) begin
      if (state_reg == ST_SYNC && !sync_done) begin
        sync_cnt_reg <= sync_cnt_reg + 2'h1;
        enc_reg      <= (sync_cnt_reg == 2'h0);
      end else if (sync_go) begin
        state_reg    <= ST_SYNC;
        sync_cnt_reg <= 2'h0;
        enc_reg      <= 1'b1;
      end else begin
        state_reg   <= ST_DATA;
        enc_reg     <= enc_next;
        half_reg    <= ~new_bit;
        bit_idx_reg <= new_bit ? next_idx : bit_idx_reg;
      end
    end
  end

  // ****************************************************************
  // Modulator
  // ****************************************************************
  logic [1:0] sub_cnt_reg;
  logic [3:0] fsk_cnt_reg;
  logic       fsk_sq_reg;
  logic       psk_ph_reg;
  logic       enc_d_reg;
  logic       subcar;
  logic       fsk_end;
  logic       psk_flip;
  logic       load_next;

  assign subcar  = cfg_reg.psk_carrier_divider ? sub_cnt_reg[1] : sub_cnt_reg[0];
  assign fsk_end = (fsk_cnt_reg >= (enc_reg ? FSK_ONE_HALF : FSK_ZERO_HALF) - 4'h1);
  // Phase flips on a data change, or at the start of each one bit
  assign psk_flip = (mod_mode == MOD_PSK_CHG) ? (enc_reg != enc_d_reg)
                                              : (bit_start & next_d);

  always_comb begin
    load_next = enc_reg;
    unique case (mod_mode)
      MOD_DIRECT:  load_next = enc_reg;
      MOD_FSK:     load_next = fsk_sq_reg;
      MOD_PSK_CHG: load_next = subcar ^ psk_ph_reg;
      MOD_PSK_ONE: load_next = subcar ^ psk_ph_reg;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst_int) begin
      sub_cnt_reg <= 2'h0;
      fsk_cnt_reg <= 4'h0;
      fsk_sq_reg  <= 1'b0;
      psk_ph_reg  <= 1'b0;
      enc_d_reg   <= 1'b0;
    end else begin
      sub_cnt_reg <= sub_cnt_reg + 2'h1;
      fsk_cnt_reg <= fsk_end ? 4'h0 : fsk_cnt_reg + 4'h1;
      fsk_sq_reg  <= fsk_sq_reg ^ fsk_end;
      enc_d_reg   <= enc_reg;
      psk_ph_reg  <= psk_ph_reg ^ (mod_mode[1] & psk_flip);
    end
  end

  // ****************************************************************
  // Register port and outputs
  // ****************************************************************
  logic [15:0] rd_mux;
  logic [15:0] status_word;
  assign status_word = {1'b0, bit_idx_reg, 5'h00, prog_s.active, lock_reg, gap_flag_reg};
  assign rd_mux = (reg_addr == REG_CONFIG) ? {4'h0, lock_reg, cfg_reg[10:0]} :
                  (reg_addr == REG_STATUS) ? status_word : 16'h0000;

  // Outputs all from flops; load is released while held in reset
  always_ff @(posedge mclk) begin
    if (rst_int) begin
      reg_rdata <= 16'h0000;
      coil_load <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
      coil_load <= load_next;
    end
  end

  assign field_gap    = field_gap_reg;
  assign array_locked = lock_reg;
  assign tag_in_reset = tag_in_reset_reg;

endmodule

`default_nettype wire

// >>> verification/rte_tag_encoder_assertions.sv
// Concurrent checks on the tag encoder ports.
// Assumes a bind into rte_tag_encoder and one clock, mclk.
`default_nettype none

// ****************************************************************
// Port checker
// ****************************************************************
module rte_chk
  import rte_pkg::*;
(
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        carrier_present,
  input wire logic        supply_ok,
  input wire logic [1:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        coil_load,
  input wire logic        field_gap,
  input wire logic        array_locked,
  input wire logic        tag_in_reset
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Run length of the coil level; restarts in reset and in gaps where the field is gone
  logic [7:0] run_reg;
  logic       prev_reg;
  always_ff @(posedge mclk) begin
    prev_reg <= coil_load;
    run_reg  <= (sys_rst || tag_in_reset || !carrier_present || coil_load != prev_reg) ? 8'h00 : run_reg + 8'h01;
  end

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data not idle");
  a_unmapped_zero: assert property ($past(reg_rd && reg_addr[1]) |-> reg_rdata == 16'h0000) else $error("unmapped read");
  a_fixed_zero: assert property ($past(reg_rd && reg_addr == REG_CONFIG) |-> !reg_rdata[10])
    else $error("fixed bit not zero");
  a_cfg_lock_copy: assert property ($past(reg_rd && reg_addr == REG_CONFIG) |-> reg_rdata[11] == $past(array_locked))
    else $error("config lock bit wrong");
  a_sts_lock_copy: assert property ($past(reg_rd && reg_addr == REG_STATUS) |-> reg_rdata[1] == $past(array_locked))
    else $error("status lock bit wrong");
  a_lock_sticky: assert property (array_locked && supply_ok |=> array_locked) else $error("lock dropped");
  a_gap_pulse: assert property (field_gap |=> !field_gap) else $error("gap pulse too long");
  a_gap_absent: assert property (field_gap |-> !$past(carrier_present, 8)) else $error("gap with field");
  a_supply_reset: assert property (!supply_ok [*5] |-> tag_in_reset) else $error("no reset on low supply");
  a_reset_quiet: assert property (tag_in_reset |-> !coil_load && !field_gap) else $error("active in reset");
  a_fsk_native: assert property (!array_locked && !tag_in_reset |-> run_reg < 8'd20)
    else $error("no FSK while unlocked");

  // Main scenarios reached
  c_gap: cover property (field_gap);
  c_lock: cover property ($rose(array_locked));
  c_status: cover property ($past(reg_rd && reg_addr == REG_STATUS));
endmodule

bind rte_tag_encoder rte_chk u_chk (
  .mclk            (mclk),
  .sys_rst         (sys_rst),
  .carrier_present (carrier_present),
  .supply_ok       (supply_ok),
  .reg_addr        (reg_addr),
  .reg_rd          (reg_rd),
  .reg_rdata       (reg_rdata),
  .coil_load       (coil_load),
  .field_gap       (field_gap),
  .array_locked    (array_locked),
  .tag_in_reset    (tag_in_reset)
);

`default_nettype wire

// >>> verification/rte_reader_model.sv
// Interrogator model: carrier field with commanded gaps, load change counter.
// Assumes the bench makes the carrier clock and pulses gap_go for one cycle.
`default_nettype none

// ****************************************************************
// Reader field and load watcher
// ****************************************************************
module rte_reader_model (
  input  wire logic       mclk,
  input  wire logic       gap_go,
  input  wire logic [7:0] gap_len,
  input  wire logic       coil_load,
  output logic            carrier_present,
  output logic [15:0]     edge_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  off_reg  = 8'h00;
  logic        seen_reg = 1'b0;
  logic        car_reg  = 1'b1;  // Field is on from the start
  logic [15:0] cnt_reg  = 16'h0000;

  // One driver per output
  assign carrier_present = car_reg;
  assign edge_cnt        = cnt_reg;

  // Field switched off for gap_len + 1 cycles; load changes counted for rate checks
  always @(posedge mclk) begin
    seen_reg <= coil_load;
    if (coil_load !== seen_reg) cnt_reg <= cnt_reg + 16'h0001;
    if (gap_go) off_reg <= gap_len;
    else if (off_reg != 8'h00) off_reg <= off_reg - 8'h01;
    car_reg <= (off_reg == 8'h00) && !gap_go;
  end
endmodule

`default_nettype wire

// >>> verification/rte_testbench.sv
// Bench for the tag encoder: registers, gaps, native FSK, programming, read stream.
// Assumes rte_reader_model stands for the interrogator field.
`default_nettype none

// ****************************************************************
// Testbench top
// ****************************************************************
module testbench
  import rte_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, sys_rst, supply_ok, lock_fuse, reg_wr, reg_rd, gap_go;
  logic        coil_load, field_gap, array_locked, tag_in_reset, carrier_present, hit, ok;
  rte_cfg_t    cfg_fuse;
  rte_prog_t   prog_pins;
  logic [1:0]  reg_addr;
  logic [7:0]  gap_len;
  logic [15:0] reg_wdata, reg_rdata, edge_cnt, rd, n0;
  logic [31:0] seed;
  logic [63:0] code;
  logic        samp [2048];
  int          fail_count, num_checks;

  rte_tag_encoder uut (.mclk(mclk), .sys_rst(sys_rst), .carrier_present(carrier_present),
    .supply_ok(supply_ok), .cfg_fuse(cfg_fuse), .lock_fuse(lock_fuse), .prog_pins(prog_pins),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .coil_load(coil_load), .field_gap(field_gap), .array_locked(array_locked), .tag_in_reset(tag_in_reset));
  rte_reader_model u_reader (.mclk(mclk), .gap_go(gap_go), .gap_len(gap_len), .coil_load(coil_load),
    .carrier_present(carrier_present), .edge_cnt(edge_cnt));

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Config read shows bits 10..0 with the lock state on top; the fixed bit always reads zero
  function automatic logic [15:0] exp_cfg(rte_cfg_t c, logic lk);
    return {4'h0, lk, 1'b0, c[9:0]};
  endfunction

  task automatic tick(int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic check_word(logic [15:0] got, logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_flag(logic got, logic exp);
    check_word({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic reg_write(logic [1:0] a, logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic reg_read(logic [1:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic gap(logic [7:0] n);
    @(posedge mclk);
    gap_len <= n;
    gap_go <= 1'b1;
    @(posedge mclk);
    gap_go <= 1'b0;
    tick(n + 10);
  endtask
  // Pins pass a two-stage sync, so each phase lasts several cycles
  task automatic strobe(logic v);
    prog_pins.bit_val <= v;
    tick(2);
    prog_pins.bit_stb <= 1'b1;
    tick(3);
    prog_pins.bit_stb <= 1'b0;
    tick(3);
  endtask
  // Sample the load every cycle, then look for the code in half-bit steps of four cycles
  task automatic scan(logic manch);
    for (int c = 0; c < 2048; c++) begin
      @(posedge mclk);
      #1 samp[c] = coil_load;
    end
    hit = 1'b0;
    for (int ph = 0; ph < 4; ph++) begin
      for (int r = 0; r < 256; r++) begin
        ok = 1'b1;
        for (int h = 0; h < 256; h++) if (samp[ph + 4 * (r + h)] !== (code[(h / 2) % 64] ^ (manch & h[0]))) ok = 1'b0;
        if (ok) hit = 1'b1;
      end
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Carrier clock, 20 ns period
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Watchdog well beyond the roughly 6100 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    $display("Error at %0t: timeout", $time);
    finish_test();
  end

  // Main sequence
  initial begin
    seed = lfsr(32'h0f1e_c255);
    {sys_rst, supply_ok, lock_fuse, reg_wr, reg_rd, gap_go} = 6'b110000;
    {reg_addr, gap_len, reg_wdata, prog_pins} = '0;
    cfg_fuse = rte_cfg_t'({2'b01, seed[0], 8'h00, 1'b1});  // Fixed bit set in the fuse on purpose
    tick(4);
    sys_rst <= 1'b0;
    tick(2);
    reg_read(REG_CONFIG, rd);
    check_word(rd, exp_cfg(cfg_fuse, 1'b0));
    seed = lfsr(seed);
    reg_write(REG_CONFIG, seed[15:0]);
    reg_read(REG_CONFIG, rd);
    check_word(rd, exp_cfg(cfg_fuse, 1'b0));
    for (int a = 2; a < 4; a++) begin
      reg_write(2'(a), seed[31:16]);
      reg_read(2'(a), rd);
      check_word(rd, 16'h0000);
    end
    // Erase, then count load changes at carrier/8 to carrier/10
    prog_pins.active <= 1'b1;
    tick(4);
    prog_pins.erase <= 1'b1;
    tick(4);
    prog_pins.erase <= 1'b0;
    tick(4);
    prog_pins.active <= 1'b0;
    tick(10);
    n0 = edge_cnt;
    tick(800);
    n0 = edge_cnt - n0;
    check_flag(n0 >= 16'd155 && n0 <= 16'd205, 1'b1);
    // Short gap ignored, long gap flagged and cleared by writing one
    gap(8'd8);
    reg_read(REG_STATUS, rd);
    check_word({13'h0000, rd[2:0]}, 16'h0000);
    gap(8'd30);
    reg_read(REG_STATUS, rd);
    check_flag(rd[STS_GAP], 1'b1);
    reg_write(REG_STATUS, 16'h0001);
    reg_read(REG_STATUS, rd);
    check_flag(rd[STS_GAP], 1'b0);
    // A 64-bit code written twice fills the array, first bit first
    code = {lfsr(seed), seed};
    prog_pins.active <= 1'b1;
    tick(4);
    for (int i = 0; i < 128; i++) strobe(code[i % 64]);
    for (int k = 0; k < 20 && array_locked !== 1'b1; k++) tick(1);
    #1 check_flag(array_locked, 1'b1);
    tick(1);
    lock_fuse <= 1'b1;  // The lock cell now holds the lock for the next power-up
    // Locked: erase and extra strobes must leave the array alone
    prog_pins.erase <= 1'b1;
    tick(4);
    prog_pins.erase <= 1'b0;
    tick(4);
    for (int i = 0; i < 4; i++) strobe(~code[i]);
    prog_pins.active <= 1'b0;
    reg_read(REG_STATUS, rd);
    check_flag(rd[STS_LOCK], 1'b1);
    tick(10);
    // Direct data at carrier/8; find the code at some phase and rotation
    scan(1'b0);
    check_flag(hit, 1'b1);
    // Supply loss holds the core in reset; a new factory word is caught on release
    @(posedge mclk);
    supply_ok <= 1'b0;
    cfg_fuse  <= rte_cfg_t'({2'b00, seed[1], 4'b0010, 5'h01});  // Manchester, direct load, 128 bits
    tick(6);
    #1 check_flag(tag_in_reset, 1'b1);
    tick(1);
    supply_ok <= 1'b1;
    tick(8);
    #1 check_flag(tag_in_reset, 1'b0);
    check_flag(array_locked, 1'b1);
    reg_read(REG_CONFIG, rd);
    check_word(rd, exp_cfg(cfg_fuse, 1'b1));
    tick(10);
    // Manchester: each bit sends its value, then its inverse
    scan(1'b1);
    check_flag(hit, 1'b1);
    finish_test();
  end
endmodule

`default_nettype wire
